// [core_flags_pkg.sv]
// Constants for the core flags register and timer option register
package core_flags_pkg;
	// Avalon word indices; the byte address is four times the index
	localparam logic [10:0] FLAGS_IDX_BANK0 = 11'h003;
	localparam logic [10:0] FLAGS_IDX_BANK1 = 11'h083;
	localparam logic [10:0] FLAGS_IDX_BANK2 = 11'h103;
	localparam logic [10:0] FLAGS_IDX_BANK3 = 11'h183;
	localparam logic [10:0] OPTION_IDX_BANK1 = 11'h081;
	localparam logic [10:0] OPTION_IDX_BANK3 = 11'h181;
	// Field positions of the core flags register
	localparam int BIT_IND_BANK    = 7;
	localparam int BIT_RPH         = 6;
	localparam int BIT_RPL         = 5;
	localparam int BIT_TIMEOUT_N   = 4;
	localparam int BIT_POWERDOWN_N = 3;
	localparam int BIT_Z           = 2;
	localparam int BIT_NIB_CARRY   = 1;
	localparam int BIT_C           = 0;
	// Field positions of the timer option register
	localparam int OPT_PULLUP_N = 7;
	localparam int OPT_INT_EDGE = 6;
	localparam int OPT_TMR_SRC  = 5;
	localparam int OPT_TMR_EDGE = 4;
	localparam int OPT_PRESCALE_SEL = 3;
	// Reset values
	localparam logic [7:0] FLAGS_RESET  = 8'h18;
	localparam logic [7:0] OPTION_RESET = 8'hff;
	// Bank base addresses
	localparam logic [8:0] BANK0_BASE = 9'h000;
	localparam logic [8:0] BANK1_BASE = 9'h080;
	localparam logic [8:0] BANK2_BASE = 9'h100;
	localparam logic [8:0] BANK3_BASE = 9'h180;
	// Avalon answer for unmapped reads
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
	// Cycles from request to waitrequest low
	localparam int BUS_WAIT_CYCLES = 1;
endpackage

// [flag_bit_cell.sv]
// One status flag cell where hardware update wins over software write
`timescale 1ns/100ps
`default_nettype none
module flag_bit_cell #(
	parameter logic RESET_VAL = 1'b0
) (
	input  wire logic core_clk,
	input  wire logic resetn,
	input  wire logic sw_we,
	input  wire logic sw_d,
	input  wire logic hw_we,
	input  wire logic hw_d,
	output logic      q_r
);
	// Hardware update takes priority over a same-cycle software write
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			q_r <= RESET_VAL;
		end else if (hw_we) begin
			q_r <= hw_d;
		end else if (sw_we) begin
			q_r <= sw_d;
		end
	end
endmodule // flag_bit_cell
`default_nettype wire

// [core_flags_bank.sv]
// Core flags and bank select register with timer option register
//
// Notes on behaviour
// - One flags register answers at 03h, 83h, 103h and 183h in all banks.
// - Direct bank value 11 selects bank from 180h and 10 the 100h-17Fh bank.
// - Direct bank value 00 selects 00h-7Fh and 01 the bank from 80h.
// - The timer option register is readable and writable by software.
// - The timer runs undivided only when the prescaler goes to the watchdog.
// - ALU updates of zero, digit carry and carry override a data write.
// - Software writes never change the timeout and powerdown flags.
// - In subtraction carry and digit carry read one when no borrow occurred.
`timescale 1ns/100ps
`default_nettype none
module core_flags_bank (
	input  wire logic        core_clk,
	input  wire logic        resetn,
	// Avalon-MM slave
	input  wire logic [12:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// ALU flag update from the execution logic
	input  wire logic        alu_flag_we,
	input  wire logic        alu_sub,
	input  wire logic        alu_zero,
	input  wire logic        alu_carry,
	input  wire logic        alu_digit_carry,
	// Watchdog and sleep events
	input  wire logic        watchdog_clear,
	input  wire logic        sleep_entry,
	input  wire logic        watchdog_timeout,
	// Bank and option outputs
	output logic [8:0]       direct_bank_base,
	output logic [8:0]       indirect_bank_base,
	output logic             timer_undivided,
	output logic             prescaler_to_watchdog,
	output logic [7:0]       option_out
);
	//----------------------------------------------------------------
	// Bus decode
	//----------------------------------------------------------------
	typedef enum logic [1:0] {BUS_IDLE, BUS_ACK} bus_state_t;
	bus_state_t bus_state_r;
	logic [10:0] word_idx;
	logic        hit_flags;
	logic        hit_option;
	logic        wr_flags;
	logic        wr_option;
	logic [7:0]  flags_q;
	logic [7:0]  option_r;
	logic [7:0]  wd;
	logic [2:0]  bank_sel_r;
	logic        timeout_n_r;
	logic        powerdown_n_r;
	logic        zero_q;
	logic        digit_carry_q;
	logic        carry_q;

	// Prescaler assignment bit as it comes out of reset
	localparam logic PRESCALE_INIT =
			core_flags_pkg::OPTION_RESET[core_flags_pkg::OPT_PRESCALE_SEL];

	// Register image built from its separately owned fields
	assign flags_q = {bank_sel_r, timeout_n_r, powerdown_n_r,
			zero_q, digit_carry_q, carry_q};

	// Word index from byte address
	assign word_idx = avs_address[12:2];
	assign wd       = avs_writedata[7:0];

	// One register seen in every bank
	assign hit_flags = (word_idx == core_flags_pkg::FLAGS_IDX_BANK0) ||
			(word_idx == core_flags_pkg::FLAGS_IDX_BANK1) ||
			(word_idx == core_flags_pkg::FLAGS_IDX_BANK2) ||
			(word_idx == core_flags_pkg::FLAGS_IDX_BANK3);
	assign hit_option = (word_idx == core_flags_pkg::OPTION_IDX_BANK1) ||
			(word_idx == core_flags_pkg::OPTION_IDX_BANK3);

	// Writes take effect on the edge that raises waitrequest again
	assign wr_flags  = avs_write && (bus_state_r == BUS_ACK) && hit_flags &&
			avs_byteenable[0];
	assign wr_option = avs_write && (bus_state_r == BUS_ACK) && hit_option &&
			avs_byteenable[0];

	//----------------------------------------------------------------
	// Bus handshake: one wait cycle, answer in the next
	//----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			bus_state_r     <= BUS_IDLE;
			avs_waitrequest <= 1'b1;
		end else begin
			case (bus_state_r)
				BUS_IDLE: begin
					if (avs_read || avs_write) begin
						bus_state_r     <= BUS_ACK;
						avs_waitrequest <= 1'b0;
					end
				end
				BUS_ACK: begin
					bus_state_r     <= BUS_IDLE;
					avs_waitrequest <= 1'b1;
				end
				default: begin
					bus_state_r     <= BUS_IDLE;
					avs_waitrequest <= 1'b1;
				end
			endcase
		end
	end

	// Read data registered alongside waitrequest low
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			avs_readdata <= core_flags_pkg::UNMAPPED_DATA;
		end else if (bus_state_r == BUS_IDLE && avs_read) begin
			if (hit_flags) begin
				avs_readdata <= {24'h000000, flags_q};
			end else if (hit_option) begin
				avs_readdata <= {24'h000000, option_r};
			end else begin
				avs_readdata <= core_flags_pkg::UNMAPPED_DATA;
			end
		end
	end

	//----------------------------------------------------------------
	// Bank select bits, plain software fields
	//----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			bank_sel_r <= core_flags_pkg::FLAGS_RESET[7:5];
		end else if (wr_flags) begin
			bank_sel_r <= wd[7:5];
		end
	end

	//----------------------------------------------------------------
	// Timeout and powerdown flags, hardware only
	//----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			{timeout_n_r, powerdown_n_r} <= core_flags_pkg::FLAGS_RESET[4:3];
		end else if (watchdog_timeout) begin
			timeout_n_r   <= 1'b0;
		end else if (sleep_entry) begin
			timeout_n_r   <= 1'b1;
			powerdown_n_r <= 1'b0;
		end else if (watchdog_clear) begin
			timeout_n_r   <= 1'b1;
			powerdown_n_r <= 1'b1;
		end
	end

	//----------------------------------------------------------------
	// ALU flags; a subtract hands over borrows, stored as no-borrow
	//----------------------------------------------------------------
	logic carry_hw;
	logic digit_carry_hw;
	// Borrow polarity: a set flag after subtract means nothing borrowed
	assign carry_hw       = alu_sub ? !alu_carry : alu_carry;
	assign digit_carry_hw = alu_sub ? !alu_digit_carry :
			alu_digit_carry;

	flag_bit_cell #(
		.RESET_VAL (core_flags_pkg::FLAGS_RESET[core_flags_pkg::BIT_Z])
	) u_zero (
		.core_clk (core_clk),
		.resetn   (resetn),
		.sw_we    (wr_flags),
		.sw_d     (wd[core_flags_pkg::BIT_Z]),
		.hw_we    (alu_flag_we),
		.hw_d     (alu_zero),
		.q_r      (zero_q)
	);
	flag_bit_cell #(
		.RESET_VAL (core_flags_pkg::FLAGS_RESET[core_flags_pkg::BIT_NIB_CARRY])
	) u_digit (
		.core_clk (core_clk),
		.resetn   (resetn),
		.sw_we    (wr_flags),
		.sw_d     (wd[core_flags_pkg::BIT_NIB_CARRY]),
		.hw_we    (alu_flag_we),
		.hw_d     (digit_carry_hw),
		.q_r      (digit_carry_q)
	);
	flag_bit_cell #(
		.RESET_VAL (core_flags_pkg::FLAGS_RESET[core_flags_pkg::BIT_C])
	) u_carry (
		.core_clk (core_clk),
		.resetn   (resetn),
		.sw_we    (wr_flags),
		.sw_d     (wd[core_flags_pkg::BIT_C]),
		.hw_we    (alu_flag_we),
		.hw_d     (carry_hw),
		.q_r      (carry_q)
	);

	//----------------------------------------------------------------
	// Timer option register
	//----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			option_r <= core_flags_pkg::OPTION_RESET;
		end else if (wr_option) begin
			option_r <= wd;
		end
	end

	//----------------------------------------------------------------
	// Bank base decode
	//----------------------------------------------------------------
	function automatic logic [8:0] bank_base(input logic [1:0] sel);
		case (sel)
			2'b00:   bank_base = core_flags_pkg::BANK0_BASE;
			2'b01:   bank_base = core_flags_pkg::BANK1_BASE;
			2'b10:   bank_base = core_flags_pkg::BANK2_BASE;
			default: bank_base = core_flags_pkg::BANK3_BASE;
		endcase
	endfunction

	// Registered bank and option outputs
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			direct_bank_base      <= core_flags_pkg::BANK0_BASE;
			indirect_bank_base    <= core_flags_pkg::BANK0_BASE;
			timer_undivided       <= PRESCALE_INIT;
			prescaler_to_watchdog <= PRESCALE_INIT;
			option_out            <= core_flags_pkg::OPTION_RESET;
		end else begin
			direct_bank_base <= bank_base(bank_sel_r[1:0]);
			indirect_bank_base <= bank_sel_r[2] ?
					core_flags_pkg::BANK2_BASE :
					core_flags_pkg::BANK0_BASE;
			timer_undivided <=
					option_r[core_flags_pkg::OPT_PRESCALE_SEL];
			prescaler_to_watchdog <=
					option_r[core_flags_pkg::OPT_PRESCALE_SEL];
			option_out <= option_r;
		end
	end
endmodule // core_flags_bank
`default_nettype wire

// [core_flags_asserts.sv]
// Port checker for the core flags bank
`timescale 1ns/100ps
`default_nettype none
module core_flags_asserts (
	input wire logic        core_clk,
	input wire logic        resetn,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic [8:0]  direct_bank_base,
	input wire logic [8:0]  indirect_bank_base,
	input wire logic        timer_undivided,
	input wire logic        prescaler_to_watchdog,
	input wire logic [7:0]  option_out
);
	default clocking cb @(posedge core_clk); endclocking
	// Bus answer timing and data lanes
	bus_answer_a: assert property (disable iff (!resetn)
		(avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
		else $error("no bus answer");
	wait_pulse_a: assert property (disable iff (!resetn)
		!avs_waitrequest |=> avs_waitrequest) else $error("long answer");
	upper_zero_a: assert property (disable iff (!resetn)
		avs_readdata[31:8] == 24'h000000) else $error("upper data set");
	// Bank bases and option outputs
	dir_base_a: assert property (disable iff (!resetn)
		direct_bank_base[6:0] == 7'h00) else $error("bad direct base");
	ind_base_a: assert property (disable iff (!resetn)
		indirect_bank_base[7:0] == 8'h00) else $error("bad indirect base");
	undiv_copy_a: assert property (disable iff (!resetn)
		timer_undivided == prescaler_to_watchdog) else $error("undivided");
	prescale_copy_a: assert property (disable iff (!resetn)
		prescaler_to_watchdog == option_out[3]) else $error("prescaler copy");
	// Reset state
	reset_opt_a: assert property (!resetn |=> option_out == 8'hff
		&& direct_bank_base == 9'h000) else $error("reset option");
	reset_bus_a: assert property (!resetn |=> avs_waitrequest
		&& indirect_bank_base == 9'h000) else $error("reset bus");
endmodule // core_flags_asserts
bind core_flags_bank core_flags_asserts i_chk (.core_clk, .resetn,
	.avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
	.direct_bank_base, .indirect_bank_base, .timer_undivided,
	.prescaler_to_watchdog, .option_out);
`default_nettype wire

// [core_exec_model.sv]
// Execution logic model driving ALU flag and watchdog events
`timescale 1ns/100ps
`default_nettype none
module core_exec_model (
	input  wire logic core_clk,
	output logic      alu_flag_we,
	output logic      alu_sub,
	output logic      alu_zero,
	output logic      alu_carry,
	output logic      alu_digit_carry,
	output logic      watchdog_clear,
	output logic      sleep_entry,
	output logic      watchdog_timeout
);
	initial {alu_flag_we, alu_sub, alu_zero, alu_carry} = 4'h0;
	initial {alu_digit_carry, watchdog_clear, sleep_entry} = 3'h0;
	initial watchdog_timeout = 1'b0;
	// One ALU result; a subtract hands over raw borrows
	task automatic alu_op(input logic [7:0] a, b, input logic sub);
		logic [8:0] r;
		@(posedge core_clk);
		r = sub ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
		alu_sub <= sub;
		alu_zero <= (r[7:0] == 8'h00);
		alu_carry <= sub ? (a < b) : r[8];
		alu_digit_carry <= sub ? (a[3:0] < b[3:0]) :
				(a[3:0] + b[3:0] > 5'h0f);
		alu_flag_we <= 1'b1;
		@(posedge core_clk);
		alu_flag_we <= 1'b0;
		alu_zero <= !alu_zero;
		{alu_carry, alu_digit_carry} <= ~{alu_carry, alu_digit_carry};
	endtask
	// One pulse: 0 watchdog clear, 1 sleep, 2 watchdog time-out
	task automatic wd_event(input int sel);
		@(posedge core_clk);
		{watchdog_timeout, sleep_entry, watchdog_clear} <= 3'b001 << sel;
		@(posedge core_clk);
		{watchdog_timeout, sleep_entry, watchdog_clear} <= 3'b000;
	endtask
endmodule // core_exec_model
`default_nettype wire

// [core_flags_bank_tb.sv]
// Self-checking bench for the core flags bank
`timescale 1ns/100ps
`default_nettype none
module core_flags_bank_tb;
	logic        core_clk, resetn, avs_read, avs_write, avs_waitrequest;
	logic        alu_flag_we, alu_sub, alu_zero, alu_carry, alu_digit_carry;
	logic        watchdog_clear, sleep_entry, watchdog_timeout;
	logic        timer_undivided, prescaler_to_watchdog, s;
	logic [12:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [3:0]  avs_byteenable;
	logic [8:0]  direct_bank_base, indirect_bank_base;
	logic [7:0]  option_out, m_flags, d, a, b;
	logic [10:0] flag_idx [4];
	int          err_total, n_checks, r, nib;
	core_flags_bank i_dut (.core_clk, .resetn, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest, .alu_flag_we, .alu_sub, .alu_zero, .alu_carry,
		.alu_digit_carry, .watchdog_clear, .sleep_entry,
		.watchdog_timeout, .direct_bank_base, .indirect_bank_base,
		.timer_undivided, .prescaler_to_watchdog, .option_out);
	core_exec_model i_core (.core_clk, .alu_flag_we, .alu_sub, .alu_zero,
		.alu_carry, .alu_digit_carry, .watchdog_clear, .sleep_entry,
		.watchdog_timeout);
	// Compare and count
	task automatic check(input logic [31:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One bus access, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [10:0] idx,
			input logic [7:0] wd);
		int n;
		n = 0;
		@(posedge core_clk);
		avs_address <= {idx, 2'b00};
		avs_writedata <= {24'h000000, wd};
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50) begin
			err_total++;
			end_sim();
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rd_chk(input logic [10:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h00);
		check(q, {24'h000000, exp});
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	initial begin
		#200000;
		err_total++;
		end_sim();
	end
	// Main sequence against the bench's own flags model
	initial begin
		{resetn, avs_read, avs_write} = 3'b000;
		{avs_address, avs_writedata, avs_byteenable} = {13'h0000, 32'h0, 4'h1};
		{err_total, n_checks, m_flags} = {32'd0, 32'd0, 8'h18};
		flag_idx = '{core_flags_pkg::FLAGS_IDX_BANK0, core_flags_pkg::FLAGS_IDX_BANK1,
			core_flags_pkg::FLAGS_IDX_BANK2, core_flags_pkg::FLAGS_IDX_BANK3};
		void'($urandom(32'hab66b0f8));
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		for (int i = 0; i < 4; i++) rd_chk(flag_idx[i], 8'h18);
		rd_chk(core_flags_pkg::OPTION_IDX_BANK3, 8'hff);
		for (int i = 0; i < 24; i++) begin
			d = 8'($urandom());
			bus(1'b1, flag_idx[i % 4], d);
			m_flags = (d & 8'he7) | (m_flags & 8'h18);
			rd_chk(flag_idx[(i + 1) % 4], m_flags);
			check(direct_bank_base, {d[6:5], 7'h00});
			check(indirect_bank_base, {d[7], 8'h00});
			d = 8'($urandom());
			bus(1'b1, core_flags_pkg::OPTION_IDX_BANK1, d);
			rd_chk(core_flags_pkg::OPTION_IDX_BANK3, d);
			check(timer_undivided, d[3]);
			check(prescaler_to_watchdog, d[3]);
			check(option_out, d);
			a = 8'($urandom());
			b = (i % 4 == 0) ? a : 8'($urandom());
			s = 1'($urandom());
			i_core.alu_op(a, b, s);
			r = s ? int'(a) - int'(b) : int'(a) + int'(b);
			nib = int'(a % 16) + (s ? -int'(b % 16) : int'(b % 16));
			m_flags[2] = (r % 256 == 0);
			m_flags[1] = s ? nib >= 0 : nib > 15;
			m_flags[0] = s ? r >= 0 : r > 255;
			rd_chk(flag_idx[i % 4], m_flags);
			i_core.wd_event(i % 3);
			m_flags[4:3] = (i % 3 == 2) ? {1'b0, m_flags[3]} : {1'b1, i % 3 == 0};
			rd_chk(flag_idx[(i + 2) % 4], m_flags);
		end
		// Software write and ALU update land on the same edge
		d = 8'($urandom()) & 8'hf8;
		a = 8'($urandom());
		fork
			bus(1'b1, flag_idx[1], d);
			begin
				@(posedge core_clk);
				i_core.alu_op(a, a, 1'b1);
			end
		join
		m_flags = {d[7:5], m_flags[4:3], 3'b111};
		rd_chk(flag_idx[2], m_flags);
		// A write without the low byte lane changes nothing
		avs_byteenable <= 4'h0;
		bus(1'b1, flag_idx[0], ~m_flags);
		avs_byteenable <= 4'h1;
		rd_chk(flag_idx[3], m_flags);
		bus(1'b1, 11'h004, 8'hff);
		rd_chk(core_flags_pkg::FLAGS_IDX_BANK2, m_flags);
		rd_chk(11'h004, 8'h00);
		// Mid-run reset brings every field back
		@(posedge core_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		rd_chk(flag_idx[2], 8'h18);
		rd_chk(core_flags_pkg::OPTION_IDX_BANK1, 8'hff);
		check(option_out, core_flags_pkg::OPTION_RESET);
		check(timer_undivided, 1'b1);
		check(direct_bank_base, core_flags_pkg::BANK0_BASE);
		check(indirect_bank_base, core_flags_pkg::BANK0_BASE);
		end_sim();
	end
endmodule // core_flags_bank_tb
`default_nettype wire
